// file: rtl/pcfg_defs.vh
`ifndef PCFG_DEFS_VH
`define PCFG_DEFS_VH
// ------------------------------------------------------------
// register reset values
// ------------------------------------------------------------
`define PCFG_BUS_RESET 16'h9D4F
`define PCFG_REF_RESET 16'h0070
// ------------------------------------------------------------
// select bit and field positions
// ------------------------------------------------------------
`define PCFG_SEL_BIT 19
`define PCFG_DRV_LO 4
`define PCFG_WCFG_BIT 8
`define PCFG_WPOL_BIT 10
`define PCFG_LAT_LO 11
`define PCFG_MODE_BIT 15
`define PCFG_PAR_LO 0
`define PCFG_DPD_BIT 4
`define PCFG_TCR_LO 5
`define PCFG_PAGE_BIT 7
// ------------------------------------------------------------
// codes and timing
// ------------------------------------------------------------
`define PCFG_DRV_FULL 2'h0
`define PCFG_DRV_RSVD 2'h3
`define PCFG_LAT_DEF 3'h3
`define PCFG_LAT_MIN 3'h2
`define PCFG_LAT_MAX 3'h6
`define PCFG_INIT_US 150
`define PCFG_CLK_MHZ 25
`endif

// file: rtl/pcfg_regs.v
`include "pcfg_defs.vh"
`default_nettype none
module pcfg_regs #(
  parameter DENSITY_MB = 128,
  parameter INIT_CYCLES = `PCFG_INIT_US * `PCFG_CLK_MHZ
) (
  // clock and reset
  input wire clk,
  input wire rst_b,
  // configuration access from the memory bus pins
  input wire config_reg_select,
  input wire cfg_write,
  input wire [21:0] addr,
  input wire cfg_read,
  // burst sequencing from the array side
  input wire burst_start,
  input wire refresh_collision,
  input wire data_ready,
  // register contents and read path
  output reg [15:0] bus_setup_reg,
  output reg [15:0] refresh_setup_reg,
  output reg [15:0] cfg_rdata,
  // decoded settings
  output reg [1:0] drive_strength,
  output reg sync_mode,
  output reg page_mode_en,
  output reg deep_sleep_mode,
  output reg init_busy,
  output reg [1:0] temp_refresh_field,
  output reg [22:0] refresh_lo,
  output reg [22:0] refresh_hi,
  output reg refresh_none,
  // wait and data timing
  output reg wait_pin,
  output reg data_valid,
  output reg first_data
);

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  reg [24:0] sync1_reg;
  reg [24:0] sync2_reg;
  // config accesses arrive from pins, so they cross first
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1_reg <= 25'h0000000;
      sync2_reg <= 25'h0000000;
    end else begin
      sync1_reg <= {config_reg_select, cfg_write, cfg_read, addr};
      sync2_reg <= sync1_reg;
    end
  end
  wire s_sel = sync2_reg[24];
  wire s_wr = sync2_reg[23];
  wire s_rd = sync2_reg[22];
  wire [21:0] s_addr = sync2_reg[21:0];
  reg wr_d_reg;
  wire wr_pulse = s_wr & ~wr_d_reg & s_sel;

  // ------------------------------------------------------------
  // register writes
  // ------------------------------------------------------------
  // capture on the rising edge of the write strobe only
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_d_reg <= 1'b0;
      bus_setup_reg <= `PCFG_BUS_RESET;
      refresh_setup_reg <= `PCFG_REF_RESET;
    end else begin
      wr_d_reg <= s_wr;
      if (wr_pulse && s_addr[`PCFG_SEL_BIT])
        bus_setup_reg <= s_addr[15:0];
      if (wr_pulse && !s_addr[`PCFG_SEL_BIT])
        refresh_setup_reg <= s_addr[15:0];
    end
  end

  // read path: other address bits are ignored
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      cfg_rdata <= 16'h0000;
    else if (s_sel && s_rd)
      cfg_rdata <= s_addr[`PCFG_SEL_BIT] ? bus_setup_reg : refresh_setup_reg;
  end

  // ------------------------------------------------------------
  // field decode
  // ------------------------------------------------------------
  wire [1:0] drv_f = bus_setup_reg[`PCFG_DRV_LO+1:`PCFG_DRV_LO];
  wire [2:0] lat_f = bus_setup_reg[`PCFG_LAT_LO+2:`PCFG_LAT_LO];
  wire wcfg = bus_setup_reg[`PCFG_WCFG_BIT];
  wire wpol = bus_setup_reg[`PCFG_WPOL_BIT];
  wire [2:0] par_f = refresh_setup_reg[`PCFG_PAR_LO+2:`PCFG_PAR_LO];
  wire dpd_en = ~refresh_setup_reg[`PCFG_DPD_BIT];
  // reserved latency codes fall back to the default
  wire [2:0] lat_eff = (lat_f < `PCFG_LAT_MIN || lat_f > `PCFG_LAT_MAX) ?
    `PCFG_LAT_DEF : lat_f;

  // latency count: code+1 clocks, twice the code on refresh collision
  function [3:0] lat_clocks;
    input [2:0] code;
    input coll;
    begin
      lat_clocks = {1'b0, code} + 4'h1;
      if (coll)
        lat_clocks = {code, 1'b0};
    end
  endfunction

  // partial refresh window in words for a die of total words
  // sizes are worked in 24 bits so the full 8M word die does not wrap
  function [45:0] par_range;
    input [2:0] code;
    input [23:0] words;
    reg [23:0] sz;
    reg [23:0] lo;
    reg [23:0] hi;
    begin
      sz = 24'h000000;
      case (code[1:0])
        2'h0: sz = words;
        2'h1: sz = words - (words >> 2);
        2'h2: sz = words >> 1;
        default: sz = words >> 2;
      endcase
      // the largest die halves its window at every step instead
      if (DENSITY_MB == 128)
        sz = words >> code[1:0];
      lo = code[2] ? words - sz : 24'h000000;
      hi = code[2] ? words - 24'h000001 : sz - 24'h000001;
      par_range = {lo[22:0], hi[22:0]};
    end
  endfunction

  wire [23:0] die_words = (DENSITY_MB == 128) ? 24'h800000 :
    (DENSITY_MB == 64) ? 24'h400000 : 24'h200000;
  wire [45:0] rng = par_range(par_f, die_words);

  // ------------------------------------------------------------
  // decoded outputs
  // ------------------------------------------------------------
  // decodes lag the stored fields by one clock
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      drive_strength <= `PCFG_DRV_FULL;
      sync_mode <= 1'b0;
      page_mode_en <= 1'b0;
      temp_refresh_field <= 2'h3;
      refresh_lo <= 23'h000000;
      refresh_hi <= 23'h7FFFFF;
      refresh_none <= 1'b0;
      deep_sleep_mode <= 1'b0;
    end else begin
      drive_strength <= (drv_f == `PCFG_DRV_RSVD) ? `PCFG_DRV_FULL : drv_f;
      sync_mode <= ~bus_setup_reg[`PCFG_MODE_BIT];
      page_mode_en <= refresh_setup_reg[`PCFG_PAGE_BIT] & bus_setup_reg[`PCFG_MODE_BIT];
      temp_refresh_field <= refresh_setup_reg[`PCFG_TCR_LO+1:`PCFG_TCR_LO];
      refresh_lo <= rng[45:23];
      refresh_hi <= rng[22:0];
      refresh_none <= (par_f == 3'h4) | dpd_en;
      deep_sleep_mode <= dpd_en;
    end
  end

  // ------------------------------------------------------------
  // wake-up timer after deep sleep
  // ------------------------------------------------------------
  reg [31:0] init_cnt_reg;
  reg dpd_d_reg;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dpd_d_reg <= 1'b0;
      init_cnt_reg <= 32'h00000000;
      init_busy <= 1'b0;
    end else begin
      dpd_d_reg <= dpd_en;
      if (dpd_d_reg && !dpd_en) begin
        init_cnt_reg <= INIT_CYCLES;
        init_busy <= 1'b1;
      end else if (init_cnt_reg != 32'h00000000) begin
        init_cnt_reg <= init_cnt_reg - 32'h00000001;
        init_busy <= (init_cnt_reg != 32'h00000001);
      end
    end
  end

  // ------------------------------------------------------------
  // burst latency and wait sequencing
  // ------------------------------------------------------------
  localparam ST_IDLE = 3'h1;
  localparam ST_LAT = 3'h2;
  localparam ST_DATA = 3'h4;
  reg [2:0] state_reg;
  reg [3:0] lat_cnt_reg;
  reg ready_reg;
  // wait pin uses its asserted level from polarity; the controller
  // must honour it, an ignored wait costs it data
  wire busy_next = (state_reg != ST_DATA) | ~ready_reg;
  // early wait drops while two latency clocks remain, one clock ahead of data
  wire wait_asserted = wcfg ? ((state_reg == ST_LAT && lat_cnt_reg > 4'h2) |
    (state_reg == ST_DATA && !data_ready)) : busy_next;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= ST_IDLE;
      lat_cnt_reg <= 4'h0;
      ready_reg <= 1'b0;
      wait_pin <= 1'b0;
      data_valid <= 1'b0;
      first_data <= 1'b0;
    end else begin
      first_data <= 1'b0;
      ready_reg <= data_ready;
      wait_pin <= (sync_mode && state_reg != ST_IDLE) ? ~(wait_asserted ^ wpol) : 1'b0;
      case (state_reg)
        ST_IDLE: begin
          data_valid <= 1'b0;
          if (burst_start && sync_mode && !init_busy) begin
            lat_cnt_reg <= lat_clocks(lat_eff, refresh_collision);
            state_reg <= ST_LAT;
          end
        end
        ST_LAT: begin
          if (lat_cnt_reg == 4'h1) begin
            state_reg <= ST_DATA;
            data_valid <= 1'b1;
            first_data <= 1'b1;
          end else
            lat_cnt_reg <= lat_cnt_reg - 4'h1;
        end
        ST_DATA: begin
          data_valid <= data_ready;
          if (!burst_start)
            state_reg <= ST_IDLE;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

endmodule
`default_nettype wire

// file: bench/pcfg_checker.sv
`default_nettype none
module pcfg_checker (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // configuration pins
  input wire logic config_reg_select,
  input wire logic cfg_write,
  input wire logic [21:0] addr,
  // stored values and decodes
  input wire logic [15:0] bus_setup_reg,
  input wire logic [15:0] refresh_setup_reg,
  input wire logic [1:0] drive_strength,
  input wire logic sync_mode,
  input wire logic deep_sleep_mode,
  input wire logic [1:0] temp_refresh_field,
  input wire logic refresh_none,
  // burst timing
  input wire logic wait_pin,
  input wire logic data_valid,
  input wire logic first_data
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // a write starts when the strobe rises with the select held
  sequence s_req;
    $rose(cfg_write) && config_reg_select;
  endsequence
  sequence s_bus_wr;
    s_req ##0 addr[19];
  endsequence
  a_bus_write: assert property (s_bus_wr |-> ##[1:4] bus_setup_reg == addr[15:0])
    else $error("bus setup write lost");
  a_ref_write: assert property (s_req ##0 !addr[19] |-> ##[1:4] refresh_setup_reg == addr[15:0])
    else $error("refresh setup write lost");
  a_unselected_write: assert property ($rose(cfg_write) && !config_reg_select |=> $stable(bus_setup_reg) [*4])
    else $error("write taken without select");
  // decodes follow the stored fields one cycle later
  a_drive_decode: assert property (drive_strength == (($past(bus_setup_reg[5:4]) == 2'h3) ? 2'h0 : $past(bus_setup_reg[5:4])))
    else $error("drive strength decode wrong");
  a_mode_decode: assert property (sync_mode == !$past(bus_setup_reg[15]))
    else $error("operating mode decode wrong");
  a_sleep_decode: assert property (deep_sleep_mode == !$past(refresh_setup_reg[4]))
    else $error("deep sleep decode wrong");
  a_temp_decode: assert property (temp_refresh_field == $past(refresh_setup_reg[6:5]))
    else $error("temperature field decode wrong");
  a_none_decode: assert property (refresh_none == ($past(refresh_setup_reg[2:0]) == 3'h4 || !$past(refresh_setup_reg[4])))
    else $error("refresh none decode wrong");
  // early wait, active high: asserted two clocks back, released one clock before data
  a_wait_lead: assert property (first_data && bus_setup_reg[8] && bus_setup_reg[10] |-> !wait_pin && !$past(wait_pin) && $past(wait_pin, 2))
    else $error("wait does not lead first data");
  a_wait_async: assert property (!$past(sync_mode) |-> !wait_pin)
    else $error("wait active in asynchronous mode");
  a_first_valid: assert property (first_data |-> data_valid)
    else $error("first data without valid");
endmodule
`default_nettype wire

// file: bench/pcfg_host.sv
`default_nettype none
module pcfg_host (
  // clock
  input wire logic clk,
  // pins toward the device
  output logic config_reg_select,
  output logic cfg_write,
  output logic cfg_read,
  output logic [21:0] addr,
  output logic burst_start,
  output logic refresh_collision,
  // answers from the device
  input wire logic [15:0] cfg_rdata,
  input wire logic first_data
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {config_reg_select, cfg_write, cfg_read, burst_start, refresh_collision} = 5'h00;
    addr = 22'h000000;
  end
  // pins hold for the sync delay; afterwards addr is inverted so no stale value lingers
  task automatic wr(input logic sel, input logic bus, input logic [15:0] v);
    @(negedge clk);
    config_reg_select = sel;
    addr = {2'h0, bus, 3'h0, v};
    cfg_write = 1'b1;
    repeat (6) @(negedge clk);
    cfg_write = 1'b0;
    repeat (2) @(negedge clk);
    config_reg_select = 1'b0;
    addr = ~addr;
  endtask
  task automatic rd(input logic bus, output logic [15:0] v);
    @(negedge clk);
    config_reg_select = 1'b1;
    addr = {2'h0, bus, 19'h00000};
    cfg_read = 1'b1;
    repeat (6) @(negedge clk);
    v = cfg_rdata;
    {cfg_read, config_reg_select} = 2'h0;
  endtask
  // waits on the device before taking data, gives up after 40 clocks
  task automatic burst(input logic coll, output int n);
    @(negedge clk);
    {burst_start, refresh_collision} = {1'b1, coll};
    n = 0;
    @(negedge clk);
    burst_start = 1'b0;
    while (first_data !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    refresh_collision = 1'b0;
    repeat (12) @(negedge clk);
  endtask
endmodule
`default_nettype wire

// file: bench/pcfg_tb.sv
`default_nettype none
bind pcfg_regs pcfg_checker chk_i (.clk, .rst_b, .config_reg_select, .cfg_write, .addr,
  .bus_setup_reg, .refresh_setup_reg, .drive_strength, .sync_mode, .deep_sleep_mode,
  .temp_refresh_field, .refresh_none, .wait_pin, .data_valid, .first_data);
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst_b;
  wire config_reg_select, cfg_write, cfg_read, burst_start, refresh_collision;
  wire [21:0] addr;
  wire [15:0] bus_setup_reg, refresh_setup_reg, cfg_rdata;
  wire [1:0] drive_strength, temp_refresh_field;
  wire sync_mode, page_mode_en, deep_sleep_mode, init_busy, refresh_none;
  wire wait_pin, data_valid, first_data;
  wire [22:0] refresh_lo, refresh_hi;
  int bad_count = 0, n_tests = 0, n[4], nc[4];
  int lat[4] = '{2, 3, 6, 7};
  logic [15:0] v;
  logic [22:0] sz;
  // short init count keeps the wake-up wait small
  pcfg_regs #(.INIT_CYCLES(20)) DUT (.clk, .rst_b, .config_reg_select, .cfg_write, .addr,
    .cfg_read, .burst_start, .refresh_collision, .data_ready(1'b1), .bus_setup_reg,
    .refresh_setup_reg, .cfg_rdata, .drive_strength, .sync_mode, .page_mode_en,
    .deep_sleep_mode, .init_busy, .temp_refresh_field, .refresh_lo, .refresh_hi,
    .refresh_none, .wait_pin, .data_valid, .first_data);
  pcfg_host h (.clk, .config_reg_select, .cfg_write, .cfg_read, .addr, .burst_start,
    .refresh_collision, .cfg_rdata, .first_data);
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks=%0d mismatches=%0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // watchdog well past the few hundred clocks the tests need
  initial begin
    #400000;
    bad_count++;
    finish_test();
  end
  initial begin
    rst_b = 1'b0;
    repeat (16) @(negedge clk);
    rst_b = 1'b1;
    h.rd(1'b1, v);
    chk(v, 16'h9D4F);
    h.rd(1'b0, v);
    chk(v, 16'h0070);
    chk({sync_mode, page_mode_en, drive_strength}, 4'h0);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      h.wr(1'b1, 1'b1, 16'h9D4F | (i << 4));
      chk(drive_strength, (i == 3) ? 0 : i);
    end
    h.rd(1'b1, v);
    chk(v, 16'h9D7F);
    h.wr(1'b0, 1'b1, 16'h0000);
    chk(bus_setup_reg, 16'h9D7F);
    $display("test drive done");
    // synchronous mode with latency codes 2, 3, 6 and reserved 7, plain and colliding
    foreach (lat[i]) begin
      h.wr(1'b1, 1'b1, 16'h054F | (lat[i] << 11));
      h.burst(1'b0, n[i]);
      h.burst(1'b1, nc[i]);
    end
    chk(n[1] - n[0], 1);
    chk(n[2] - n[0], 4);
    chk(nc[0] - n[0], 1);
    chk(nc[1] - n[1], 2);
    chk({n[3], nc[3]}, {n[1], nc[1]});
    $display("test latency done");
    h.wr(1'b1, 1'b1, 16'h9D4F);
    for (int c = 0; c < 8; c++) begin
      h.wr(1'b1, 1'b0, 16'h0090 | c);
      sz = 23'h7FFFFF >> c[1:0];
      chk(refresh_none, c == 4);
      if (c != 4) chk({refresh_lo, refresh_hi}, c[2] ? {~sz, 23'h7FFFFF} : {23'h0, sz});
      chk({page_mode_en, temp_refresh_field}, 3'h4);
    end
    $display("test refresh done");
    h.wr(1'b1, 1'b0, 16'h0060);
    chk({deep_sleep_mode, refresh_none}, 2'h3);
    h.wr(1'b1, 1'b0, 16'h0070);
    chk(init_busy, 1'b1);
    repeat (30) @(negedge clk);
    chk({init_busy, deep_sleep_mode}, 2'h0);
    $display("test sleep done");
    finish_test();
  end
endmodule
`default_nettype wire
